// ---- serdes_link_setup_regs.sv ----
// Operation
// - Writing zero to power register powers interface.
// - Link counts stored as value minus one.
// - Version field: 1 revision B, 0 A.
// - Recovery reset: zero holds, one releases.
// - PLL status bit 0 shows serial lock.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module serdes_link_setup_regs #(
	parameter int SETTLE = serdes_link_pkg::PLL_SETTLE_CYC
) (
	// Clock and reset
	input  wire logic                                   clk,
	input  wire logic                                   rstn,
	// Wishbone slave
	input  wire logic                                   cyc_i,
	input  wire logic                                   stb_i,
	input  wire logic                                   we_i,
	input  wire logic [serdes_link_pkg::ADR_W-1:0]      adr_i,
	input  wire logic [3:0]                             sel_i,
	input  wire logic [31:0]                            dat_i,
	output var  logic [31:0]                            dat_o,
	output var  logic                                   ack_o,
	// Serial PLL
	input  wire logic                                   pll_lock_raw,
	output var  logic                                   serial_pll_enable,
	output var  logic                                   serial_synth_div_en,
	output var  logic [1:0]                             serial_synth_divider,
	// Interface and recovery control
	output var  logic                                   iface_powered,
	output var  logic [7:0]                             idle_lane_mask,
	output var  logic                                   cdr_hold,
	output var  logic                                   half_rate,
	output var  logic [1:0]                             recovery_oversample,
	output var  logic [1:0]                             equalizer_select,
	// Link configuration
	output var  logic                                   two_link_select,
	output var  serdes_link_pkg::link_cfg_s             link0_cfg,
	output var  serdes_link_pkg::link_cfg_s             link1_cfg
);

	localparam int SW = serdes_link_pkg::SLOT_W;
	localparam int IW = serdes_link_pkg::IDX_W;
	localparam int RW = serdes_link_pkg::REG_W;

	// Maps a register index and link page to a storage slot.
	function automatic serdes_link_pkg::slot_s slot_of(
		input logic [IW-1:0] idx,
		input logic          page
	);
		serdes_link_pkg::slot_s s;
		s = '0;
		for (int i = 0; i < serdes_link_pkg::NSHARE - 1; i++) begin
			if (idx == serdes_link_pkg::SHARE_IDX[
				(serdes_link_pkg::NSHARE-1-i)*IW +: IW]) begin
				s.hit  = 1'b1;
				s.slot = SW'(i);
			end
		end
		for (int k = 0; k < serdes_link_pkg::NPLINK; k++) begin
			if (idx == serdes_link_pkg::LINK_IDX[
				(serdes_link_pkg::NPLINK-1-k)*IW +: IW]) begin
				s.hit  = 1'b1;
				s.slot = SW'(serdes_link_pkg::NSHARE + k)
					+ (page ? SW'(serdes_link_pkg::NPLINK) : SW'(0));
			end
		end
		return s;
	endfunction

	// Slot of a per-link register on a given link.
	function automatic logic [SW-1:0] link_slot(
		input int link,
		input int k
	);
		return SW'(serdes_link_pkg::NSHARE
			+ link * serdes_link_pkg::NPLINK + k);
	endfunction

	// Register storage and bus state.
	logic [RW-1:0] regs      [serdes_link_pkg::NSLOT];
	logic [RW-1:0] next_regs [serdes_link_pkg::NSLOT];
	logic          next_ack;
	logic [31:0]   next_dat;
	logic          pll_locked;
	logic          page;
	logic [IW-1:0] idx;
	logic          upper_ok;
	logic          commit;
	serdes_link_pkg::slot_s acc;

	// Output next values.
	logic                       next_powered;
	logic [7:0]                 next_idle;
	logic                       next_cdr_hold;
	logic                       next_half;
	logic [1:0]                 next_recovery_oversample;
	logic [1:0]                 next_eq;
	logic                       next_pll_en;
	logic                       next_div_en;
	logic [1:0]                 next_div;
	logic                       next_two_link;
	serdes_link_pkg::link_cfg_s next_cfg [serdes_link_pkg::NLINK];

	serial_pll_lock_qual #(
		.SETTLE (SETTLE)
	) u_lock (
		.clk      (clk),
		.rstn     (rstn),
		.enable   (serial_pll_enable),
		.lock_raw (pll_lock_raw),
		.locked   (pll_locked)
	);

	// Link page is only honoured while dual-link operation is selected.
	assign page = regs[serdes_link_pkg::SLOT_LINK_GENERAL]
			[serdes_link_pkg::BIT_TWO_LINK]
		& regs[serdes_link_pkg::SLOT_LINK_GENERAL]
			[serdes_link_pkg::BIT_LINK_PAGE];
	assign idx      = adr_i[serdes_link_pkg::ADR_W-1:2];
	assign upper_ok = (adr_i[1:0] == 2'h0);
	assign acc      = slot_of(idx, page);
	// A write lands only on the edge at which the master sees ack.
	assign commit   = cyc_i & stb_i & we_i & ack_o & sel_i[0] & upper_ok;

	// Bus and register file next state.
	always_comb begin
		next_regs = regs;
		next_ack  = cyc_i & stb_i & ~ack_o;
		next_dat  = ack_o ? dat_o : 32'h0000_0000;
		if (commit && acc.hit) begin
			// The page selected by the link control register
			// receives per-link writes.
			next_regs[acc.slot] = dat_i[RW-1:0];
		end
		if (next_ack && !we_i) begin
			next_dat = 32'h0000_0000;
			if (!upper_ok) begin
				next_dat = 32'h0000_0000;
			end else if (idx == serdes_link_pkg::IDX_PLL_STATUS) begin
				next_dat[0] = pll_locked;
			end else if (acc.hit) begin
				next_dat[RW-1:0] = regs[acc.slot];
			end
		end
	end

	// Control outputs derived from the stored registers.
	always_comb begin
		logic [RW-1:0] gen;
		gen = regs[serdes_link_pkg::SLOT_LINK_GENERAL];
		// Zero in the power register powers the interface.
		next_powered = (regs[serdes_link_pkg::SLOT_IFACE_POWER] == 8'h00);
		next_idle    = regs[serdes_link_pkg::SLOT_IDLE_LANES];
		// Bit 0 low holds recovery in reset, high releases it.
		next_cdr_hold = ~regs[serdes_link_pkg::SLOT_RECOVERY_RST][0];
		next_half = regs[serdes_link_pkg::SLOT_RECOVERY_CFG]
			[serdes_link_pkg::BIT_HALF_RATE];
		next_recovery_oversample = regs[serdes_link_pkg::SLOT_RECOVERY_CFG]
			[serdes_link_pkg::BIT_RECOVERY_OVERSAMPLE_LO +: 2];
		next_eq = regs[serdes_link_pkg::SLOT_EQUALIZER]
			[serdes_link_pkg::BIT_EQ_LO +: 2];
		next_pll_en = regs[serdes_link_pkg::SLOT_PLL_ENABLE][0];
		next_div_en = regs[serdes_link_pkg::SLOT_PLL_DIVIDER]
			[serdes_link_pkg::BIT_DIV_ENABLE];
		next_div = regs[serdes_link_pkg::SLOT_PLL_DIVIDER][1:0];
		next_two_link = gen[serdes_link_pkg::BIT_TWO_LINK];
		for (int l = 0; l < serdes_link_pkg::NLINK; l++) begin
			logic [RW-1:0] lc;
			logic [RW-1:0] ver;
			lc  = regs[link_slot(l, serdes_link_pkg::LSLOT_LANE_COUNT)];
			ver = regs[link_slot(l, serdes_link_pkg::LSLOT_VERSION)];
			// The stored lane count is one less than the lanes.
			next_cfg[l].lane_count = {1'b0, lc[4:0]} + 6'h01;
			next_cfg[l].scrambled  = lc[serdes_link_pkg::BIT_SCRAMBLE];
			// Revision field value 1 selects revision B framing.
			next_cfg[l].rev_b = (ver[serdes_link_pkg::BIT_VERSION_LO +: 3]
				== serdes_link_pkg::REV_B);
			// A second link stays idle unless dual link is selected.
			next_cfg[l].lane_en = (l == 0 || next_two_link)
				? regs[link_slot(l, serdes_link_pkg::LSLOT_LANE_ENABLE)]
				: 8'h00;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < serdes_link_pkg::NSLOT; i++) begin
				regs[i] <= serdes_link_pkg::RST_OTHER;
			end
			regs[serdes_link_pkg::SLOT_IFACE_POWER] <=
				serdes_link_pkg::RST_IFACE_POWER;
			regs[serdes_link_pkg::SLOT_EQUALIZER] <=
				serdes_link_pkg::RST_EQUALIZER;
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			regs  <= next_regs;
			ack_o <= next_ack;
			dat_o <= next_dat;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			iface_powered        <= 1'b0;
			idle_lane_mask       <= 8'h00;
			cdr_hold             <= 1'b1;
			half_rate            <= 1'b0;
			recovery_oversample  <= 2'h0;
			equalizer_select     <= 2'h0;
			serial_pll_enable    <= 1'b0;
			serial_synth_div_en  <= 1'b0;
			serial_synth_divider <= 2'h0;
			two_link_select      <= 1'b0;
			link0_cfg            <= '0;
			link1_cfg            <= '0;
		end else begin
			iface_powered        <= next_powered;
			idle_lane_mask       <= next_idle;
			cdr_hold             <= next_cdr_hold;
			half_rate            <= next_half;
			recovery_oversample  <= next_recovery_oversample;
			equalizer_select     <= next_eq;
			serial_pll_enable    <= next_pll_en;
			serial_synth_div_en  <= next_div_en;
			serial_synth_divider <= next_div;
			two_link_select      <= next_two_link;
			link0_cfg            <= next_cfg[0];
			link1_cfg            <= next_cfg[1];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence power_zero_write;
		commit && idx == serdes_link_pkg::IDX_IFACE_POWER
			&& dat_i[7:0] == 8'h00;
	endsequence

	sequence cdr_release_write;
		commit && idx == serdes_link_pkg::IDX_RECOVERY_RST && dat_i[0];
	endsequence

	sequence cdr_hold_write;
		commit && idx == serdes_link_pkg::IDX_RECOVERY_RST && !dat_i[0];
	endsequence

	power_up_a: assert property (
		power_zero_write |-> ##2 iface_powered)
		else $error("interface not powered after zero write");

	cdr_hold_a: assert property (
		cdr_hold_write |-> ##2 cdr_hold)
		else $error("recovery not held after zero write");

	cdr_release_a: assert property (
		cdr_release_write |-> ##2 !cdr_hold)
		else $error("recovery not released after one write");

	lock_read_a: assert property (
		cyc_i && stb_i && !we_i && !ack_o && upper_ok
			&& idx == serdes_link_pkg::IDX_PLL_STATUS
		|=> ack_o && dat_o[0] == $past(pll_locked))
		else $error("pll status read does not show lock");

	lane_count_a: assert property (
		rstn |=> link0_cfg.lane_count == 6'(($past(regs[link_slot(0,
			serdes_link_pkg::LSLOT_LANE_COUNT)]) & 8'h1f) + 8'h01))
		else $error("lane count not stored minus one");

	revision_a: assert property (
		rstn |=> link1_cfg.rev_b == ($past(regs[link_slot(1,
			serdes_link_pkg::LSLOT_VERSION)][7:5]) == 3'h1))
		else $error("revision decode wrong");

	ack_pulse_a: assert property (
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

	lock_off_a: assert property (
		!serial_pll_enable |=> !pll_locked)
		else $error("lock reported while pll disabled");

	// The outputs lag the stored registers by one clock.
	sequence bus_taken;
		cyc_i && stb_i && !ack_o;
	endsequence

	sequence power_off_write;
		commit && idx == serdes_link_pkg::IDX_IFACE_POWER
			&& dat_i[7:0] != 8'h00;
	endsequence

	ack_answer_a: assert property (
		bus_taken |=> ack_o)
		else $error("request not acknowledged in one cycle");

	power_down_a: assert property (
		power_off_write |-> ##2 !iface_powered)
		else $error("interface powered after nonzero write");

	scramble_flag_a: assert property (
		rstn |=> link0_cfg.scrambled == $past(regs[link_slot(0,
			serdes_link_pkg::LSLOT_LANE_COUNT)]
			[serdes_link_pkg::BIT_SCRAMBLE]))
		else $error("scrambling flag does not follow register");

	second_count_a: assert property (
		rstn |=> link1_cfg.lane_count == 6'(($past(regs[link_slot(1,
			serdes_link_pkg::LSLOT_LANE_COUNT)]) & 8'h1f) + 8'h01))
		else $error("second lane count not stored minus one");

	first_revision_a: assert property (
		rstn |=> link0_cfg.rev_b == ($past(regs[link_slot(0,
			serdes_link_pkg::LSLOT_VERSION)][7:5]) == 3'h1))
		else $error("first link revision decode wrong");

	pll_enable_a: assert property (
		rstn |=> serial_pll_enable
			== $past(regs[serdes_link_pkg::SLOT_PLL_ENABLE][0]))
		else $error("pll enable does not follow register");

	lock_needs_enable_a: assert property (
		pll_locked |-> $past(serial_pll_enable))
		else $error("lock reported without pll enable");

	read_upper_zero_a: assert property (
		ack_o |-> dat_o[31:RW] == '0)
		else $error("read data upper bits not zero");

	second_link_idle_a: assert property (
		!two_link_select |-> link1_cfg.lane_en == 8'h00)
		else $error("second link lanes enabled in single link mode");

endmodule

`default_nettype wire

// ---- serdes_link_pkg.sv ----
package serdes_link_pkg;

	// Register bus geometry.
	localparam int ADR_W  = 13;
	localparam int IDX_W  = 11;
	localparam int REG_W  = 8;
	localparam int NLINK  = 2;
	localparam int NSHARE = 28;
	localparam int NPLINK = 15;
	localparam int NSLOT  = NSHARE + NLINK * NPLINK;
	localparam int SLOT_W = 6;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_IFACE_POWER   = 11'h200;
	localparam logic [IDX_W-1:0] IDX_IDLE_LANES    = 11'h201;
	localparam logic [IDX_W-1:0] IDX_RECOVERY_RST  = 11'h206;
	localparam logic [IDX_W-1:0] IDX_RECOVERY_CFG  = 11'h230;
	localparam logic [IDX_W-1:0] IDX_EQUALIZER     = 11'h268;
	localparam logic [IDX_W-1:0] IDX_PLL_ENABLE    = 11'h280;
	localparam logic [IDX_W-1:0] IDX_PLL_STATUS    = 11'h281;
	localparam logic [IDX_W-1:0] IDX_PLL_DIVIDER   = 11'h289;
	localparam logic [IDX_W-1:0] IDX_LINK_GENERAL  = 11'h300;
	localparam logic [IDX_W-1:0] IDX_CFG_ACCESS    = 11'h314;
	localparam logic [IDX_W-1:0] IDX_LANE_COUNT    = 11'h453;
	localparam logic [IDX_W-1:0] IDX_VERSION       = 11'h459;
	localparam logic [IDX_W-1:0] IDX_LANE_ENABLE   = 11'h47d;

	// Ordered index tables: shared slots, then one page of link slots.
	localparam logic [NSHARE*IDX_W-1:0] SHARE_IDX = {
		11'h200, 11'h201, 11'h206, 11'h230, 11'h268, 11'h280, 11'h284,
		11'h285, 11'h286, 11'h287, 11'h289, 11'h28a, 11'h28b, 11'h290,
		11'h291, 11'h294, 11'h296, 11'h297, 11'h299, 11'h29a, 11'h29c,
		11'h29f, 11'h2a0, 11'h2a7, 11'h2ae, 11'h300, 11'h314, 11'h000};
	localparam logic [NPLINK*IDX_W-1:0] LINK_IDX = {
		11'h450, 11'h451, 11'h452, 11'h453, 11'h454, 11'h455, 11'h456,
		11'h457, 11'h458, 11'h459, 11'h45a, 11'h45d, 11'h46c, 11'h476,
		11'h47d};

	// Slot numbers used by the control outputs.
	localparam int SLOT_IFACE_POWER  = 0;
	localparam int SLOT_IDLE_LANES   = 1;
	localparam int SLOT_RECOVERY_RST = 2;
	localparam int SLOT_RECOVERY_CFG = 3;
	localparam int SLOT_EQUALIZER    = 4;
	localparam int SLOT_PLL_ENABLE   = 5;
	localparam int SLOT_PLL_DIVIDER  = 10;
	localparam int SLOT_LINK_GENERAL = 25;
	localparam int LSLOT_LANE_COUNT  = 3;
	localparam int LSLOT_VERSION     = 9;
	localparam int LSLOT_LANE_ENABLE = 14;

	// Field positions.
	localparam int BIT_HALF_RATE   = 5;
	localparam int BIT_RECOVERY_OVERSAMPLE_LO    = 1;
	localparam int BIT_DIV_ENABLE  = 2;
	localparam int BIT_EQ_LO       = 6;
	localparam int BIT_TWO_LINK    = 3;
	localparam int BIT_LINK_PAGE   = 2;
	localparam int BIT_SCRAMBLE    = 7;
	localparam int BIT_VERSION_LO  = 5;

	// Field values.
	localparam logic [2:0] REV_B = 3'h1;

	// Values after reset.
	localparam logic [REG_W-1:0] RST_IFACE_POWER = 8'h01;
	localparam logic [REG_W-1:0] RST_EQUALIZER   = 8'h22;
	localparam logic [REG_W-1:0] RST_OTHER       = 8'h00;

	// Serial PLL lock must stay stable this long before it is reported.
	localparam int CLK_MHZ        = 125;
	localparam int PLL_SETTLE_NS  = 2000;
	localparam int PLL_SETTLE_CYC = (PLL_SETTLE_NS * CLK_MHZ + 999) / 1000;

	typedef struct packed {
		logic                hit;
		logic [SLOT_W-1:0]   slot;
	} slot_s;

	typedef struct packed {
		logic [7:0] lane_en;
		logic [5:0] lane_count;
		logic       scrambled;
		logic       rev_b;
	} link_cfg_s;

endpackage

// ---- serial_pll_lock_qual.sv ----
`timescale 1ns/1ns
`default_nettype none

// Reports serial PLL lock once the raw lock has been stable long enough.
module serial_pll_lock_qual #(
	parameter int SETTLE = serdes_link_pkg::PLL_SETTLE_CYC
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Control and lock
	input  wire logic enable,
	input  wire logic lock_raw,
	output var  logic locked
);

	localparam int CW = $clog2(SETTLE + 1);

	logic          sync_a;
	logic          sync_b;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          next_locked;

	always_comb begin
		next_count  = count;
		next_locked = 1'b0;
		if (!enable || !sync_b) begin
			next_count = '0;
		end else if (count != CW'(SETTLE)) begin
			next_count = count + CW'(1);
		end else begin
			next_locked = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			count  <= '0;
			locked <= 1'b0;
		end else begin
			sync_a <= lock_raw;
			sync_b <= sync_a;
			count  <= next_count;
			locked <= next_locked;
		end
	end

endmodule

`default_nettype wire

// ---- serial_pll_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// Lock only appears some cycles after enable, so early status reads see zero.
module serial_pll_model #(
	parameter int DELAY = 10
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Control and lock
	input  wire logic enable,
	output var  logic lock_raw
);
	int count;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count    <= 0;
			lock_raw <= 1'b0;
		end else if (!enable) begin
			count    <= 0;
			lock_raw <= 1'b0;
		end else begin
			count    <= (count < DELAY) ? count + 1 : count;
			lock_raw <= (count == DELAY);
		end
	end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	typedef struct packed {
		logic [10:0] idx;
		logic [7:0]  wr;
		logic [7:0]  rd;
	} row_s;

	logic                        clk = 1'b0;
	logic                        rstn = 1'b0;
	logic                        cyc_i = 1'b0;
	logic                        stb_i = 1'b0;
	logic                        we_i = 1'b0;
	logic [12:0]                 adr_i = 13'h0000;
	logic [3:0]                  sel_i = 4'h0;
	logic [31:0]                 dat_i = 32'h0000_0000;
	logic [31:0]                 dat_o;
	logic                        ack_o;
	logic                        lock_raw;
	logic                        pll_en;
	logic                        div_en;
	logic [1:0]                  divider;
	logic                        powered;
	logic [7:0]                  idle_mask;
	logic                        cdr_hold;
	logic                        half_rate;
	logic [1:0]                  oversample;
	logic [1:0]                  eq_sel;
	logic                        two_link;
	serdes_link_pkg::link_cfg_s  cfg0;
	serdes_link_pkg::link_cfg_s  cfg1;
	logic [7:0]                  rd_val;
	int                          num_errors = 0;
	int                          n_compared = 0;
	int                          cycles = 0;
	row_s                        rows [18];

	always #4 clk = ~clk;

	serial_pll_model #(.DELAY(10)) pll (.clk(clk), .rstn(rstn),
		.enable(pll_en), .lock_raw(lock_raw));

	serdes_link_setup_regs #(.SETTLE(4)) uut (.clk(clk), .rstn(rstn),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.pll_lock_raw(lock_raw), .serial_pll_enable(pll_en),
		.serial_synth_div_en(div_en), .serial_synth_divider(divider),
		.iface_powered(powered), .idle_lane_mask(idle_mask),
		.cdr_hold(cdr_hold), .half_rate(half_rate),
		.recovery_oversample(oversample), .equalizer_select(eq_sel),
		.two_link_select(two_link), .link0_cfg(cfg0), .link1_cfg(cfg1));

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			$display("FAIL %0t run did not finish", $time);
			give_verdict();
		end
	end

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %0t byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %0t bit %b expected %b", $time, got, exp);
		end
	endtask

	// One classic cycle; the answer is taken at the edge that shows ack.
	task automatic wb(input logic w, input logic [10:0] idx,
		input logic [7:0] d);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		sel_i <= 4'h1;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h00_0000, d};
		@(posedge clk);
		while (ack_o !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n == 20) begin
			num_errors++;
			$display("FAIL %0t no acknowledge", $time);
		end
		rd_val = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		@(posedge clk);
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
	endtask

	initial begin
		rows = '{
			'{11'h201, 8'h3c, 8'h3c}, '{11'h230, 8'h24, 8'h24},
			'{11'h206, 8'h00, 8'h00}, '{11'h206, 8'h01, 8'h01},
			'{11'h289, 8'h05, 8'h05}, '{11'h284, 8'h62, 8'h62},
			'{11'h285, 8'hc9, 8'hc9}, '{11'h2a0, 8'h06, 8'h06},
			'{11'h2a7, 8'h01, 8'h01}, '{11'h314, 8'h01, 8'h01},
			'{11'h450, 8'h12, 8'h12}, '{11'h451, 8'h03, 8'h03},
			'{11'h452, 8'h05, 8'h05}, '{11'h453, 8'h87, 8'h87},
			'{11'h459, 8'h20, 8'h20}, '{11'h46c, 8'h0f, 8'h0f},
			'{11'h281, 8'hff, 8'h00}, '{11'h7ff, 8'haa, 8'h00}};
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk_bit(powered, 1'b0);
		foreach (rows[i]) begin
			wb(1'b1, rows[i].idx, rows[i].wr);
			wb(1'b0, rows[i].idx, 8'h00);
			chk_byte(rd_val, rows[i].rd);
		end
		settle();
		chk_bit(half_rate, 1'b1);
		chk_byte({6'h00, oversample}, 8'h02);
		chk_bit(div_en, 1'b1);
		chk_byte({6'h00, divider}, 8'h01);
		chk_byte({2'b00, cfg0.lane_count}, 8'h08);
		chk_bit(cfg0.scrambled, 1'b1);
		chk_bit(cfg0.rev_b, 1'b1);
		chk_byte(idle_mask, 8'h3c);
		$display("test table done");

		wb(1'b1, 11'h200, 8'h00);
		wb(1'b1, 11'h206, 8'h00);
		wb(1'b1, 11'h459, 8'h40);
		wb(1'b1, 11'h268, 8'ha2);
		settle();
		chk_bit(powered, 1'b1);
		chk_bit(cdr_hold, 1'b1);
		chk_bit(cfg0.rev_b, 1'b0);
		chk_byte({6'h00, eq_sel}, 8'h02);
		wb(1'b1, 11'h206, 8'h01);
		wb(1'b1, 11'h459, 8'h00);
		settle();
		chk_bit(cdr_hold, 1'b0);
		chk_bit(cfg0.rev_b, 1'b0);
		$display("test controls done");

		wb(1'b1, 11'h300, 8'h08);
		wb(1'b1, 11'h47d, 8'h0f);
		wb(1'b1, 11'h300, 8'h0c);
		wb(1'b1, 11'h453, 8'h03);
		wb(1'b1, 11'h47d, 8'hf0);
		settle();
		chk_bit(two_link, 1'b1);
		chk_byte({2'b00, cfg1.lane_count}, 8'h04);
		chk_byte({2'b00, cfg0.lane_count}, 8'h08);
		chk_bit(cfg1.scrambled, 1'b0);
		chk_bit(cfg1.rev_b, 1'b0);
		chk_byte(cfg0.lane_en, 8'h0f);
		chk_byte(cfg1.lane_en, 8'hf0);
		wb(1'b0, 11'h201, 8'h00);
		chk_byte(rd_val, 8'h3c);
		wb(1'b1, 11'h300, 8'h08);
		wb(1'b0, 11'h47d, 8'h00);
		chk_byte(rd_val, 8'h0f);
		wb(1'b1, 11'h300, 8'h00);
		settle();
		chk_byte(cfg1.lane_en, 8'h00);
		$display("test dual link done");

		wb(1'b1, 11'h280, 8'h01);
		wb(1'b0, 11'h281, 8'h00);
		chk_byte(rd_val, 8'h00);
		chk_bit(pll_en, 1'b1);
		for (int n = 0; n < 30 && rd_val[0] !== 1'b1; n++)
			wb(1'b0, 11'h281, 8'h00);
		chk_byte(rd_val, 8'h01);
		wb(1'b1, 11'h280, 8'h00);
		settle();
		wb(1'b0, 11'h281, 8'h00);
		chk_byte(rd_val, 8'h00);
		chk_bit(pll_en, 1'b0);
		$display("test pll lock done");

		rstn <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		chk_bit(cdr_hold, 1'b1);
		chk_bit(powered, 1'b0);
		chk_bit(ack_o, 1'b0);
		rstn <= 1'b1;
		@(posedge clk);
		wb(1'b0, 11'h200, 8'h00);
		chk_byte(rd_val, 8'h01);
		wb(1'b0, 11'h268, 8'h00);
		chk_byte(rd_val, 8'h22);
		wb(1'b0, 11'h453, 8'h00);
		chk_byte(rd_val, 8'h00);
		$display("test reset done");
		give_verdict();
	end
endmodule
`default_nettype wire
